// ---- verilog/system_clock_mode_controller.sv ----
// How it works
// RL1: two-stage prescaler then 21-stage divider, main clock and state counter
// RL2: prescaler and divider cleared on reset, stop entry and stop exit
// RL3: seventh stage source picked by mode, slow osc enable and source bit
// RL4: during warm-up after stop from normal, sixth stage feeds seventh
// RL5: software keeps source bit zero in single clock or unstable slow osc
// RL6: machine cycle is four states, one main clock each
// RL7: single clock mode runs fast osc only, slow pins are ports
// RL8: reset enters NORMAL1
// RL9: idle request enters IDLE1, any interrupt returns to NORMAL1
// RL10: release with master enable set services the interrupt first
// RL11: release with master enable clear continues after the idle instruction
// RL12: halt bit enters IDLE0, only time base clock kept
// RL13: IDLE0 ends on time base source falling edge, back to NORMAL1
// RL14: timer enabled at IDLE0 entry sets its interrupt latch on return
// RL15: dual clock runs both osc, main clock fast or slow by mode
// RL16: reset gives single clock; software starts slow osc for dual mode
// RL17: NORMAL2 runs CPU on fast clock, peripherals on either
// RL18: clock select one gives SLOW2, zero gives NORMAL2
// RL19: fast osc enable clear in SLOW2 gives SLOW1, set returns to SLOW2
// RL20: software never clears slow osc enable in SLOW2
// RL21: in SLOW1, SLEEP1 and SLEEP0 the first divider stage input is stopped
// RL22: IDLE2 halts CPU, released like IDLE1 back to NORMAL2
// RL23: SLEEP0 acts as IDLE0 but resumes in SLOW1
// RL24: after stop warm-up, execution resumes after the stop instruction
//
// Added by the designer: the APB slave port and the register addresses.
module system_clock_mode_controller (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // Oscillator tick enables
    input wire logic FAST_TICK_IN,
    input wire logic SLOW_TICK_IN,
    // Wake sources
    input wire logic IRQ_REQ_IN,
    input wire logic IME_IN,
    input wire logic TB_IRQ_EN_IN,
    input wire logic STOP_RELEASE_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Clock enables and status
    output clk_mode_pkg::clk_gate_s GATES_OUT,
    output logic MAIN_CLK_EN_OUT,
    output logic [1:0] MACHINE_STATE_OUT,
    output logic CYCLE_START_OUT,
    output logic DIV_PULSE_OUT,
    output logic [7:0] TB_SRC_OUT,
    output logic IRQ_SERVICE_OUT,
    output logic RESUME_NEXT_OUT,
    output logic TB_IRQ_LATCH_OUT,
    output clk_mode_pkg::op_mode_e MODE_OUT
);
    import clk_mode_pkg::*;

    op_mode_e mode_q;
    op_mode_e stop_from_q;
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] tb_ctrl_q;
    logic [PRESCALE_BITS-1:0] pre_q;
    logic [DIVIDER_BITS-1:0] div_q;
    logic [16:0] warm_q;
    logic [1:0] state_q;
    logic tb_at_idle0_q;
    logic tb_src_prev_q;
    apb_req_s req;
    logic wr_en;
    logic clear_div;
    logic pre_tick;
    logic stage7_tick;
    logic src_sel;
    logic main_tick;
    logic tb_fall;
    logic [2:0] tb_sel;
    logic slow_mode;
    logic single_mode;
    logic [31:0] rd_data;

    function automatic logic is_slow(input op_mode_e m);
        return m inside {MODE_SLOW1, MODE_SLOW2, MODE_SLEEP0, MODE_SLEEP1, MODE_SLEEP2};
    endfunction : is_slow

    function automatic logic [16:0] warm_count(input logic [1:0] sel, input logic slow);
        case (sel)
            2'h0: return slow ? WARM_SLOW_0 : WARM_FAST_0;
            2'h1: return slow ? WARM_SLOW_1 : WARM_FAST_1;
            2'h2: return slow ? WARM_SLOW_2 : WARM_FAST_2;
            default: return slow ? WARM_SLOW_3 : WARM_FAST_3;
        endcase
    endfunction : warm_count

    assign req.paddr_ok = PADDR_IN[1:0] == 2'h0;
    assign req.paddr = PADDR_IN;
    assign req.pwrite = PWRITE_IN;
    assign req.pwdata = PWDATA_IN;
    assign wr_en = PSEL_IN && PENABLE_IN && req.pwrite;
    assign slow_mode = is_slow(mode_q);
    assign tb_sel = tb_ctrl_q[TB_SEL_LSB +: 3];

    // Divider clock path
    always_comb begin
        clear_div = (mode_q != MODE_STOP && ctrl_one_q[STOP_BIT])
            || (mode_q == MODE_STOP && STOP_RELEASE_IN); // see RL2
        // Stage one input stopped in slow-only modes
        pre_tick = FAST_TICK_IN && !(mode_q inside {MODE_SLOW1, MODE_SLEEP1, MODE_SLEEP0})
            && mode_q != MODE_STOP; // see RL21
        if (mode_q == MODE_WARMUP && !is_slow(stop_from_q)) begin
            src_sel = 1'b0; // see RL4
        end else if (slow_mode) begin
            src_sel = 1'b1; // see RL3
        end else begin
            src_sel = tb_ctrl_q[DV7_BIT] && ctrl_two_q[SLOW_EN_BIT]; // see RL3 RL5
        end
        stage7_tick = src_sel ? (SLOW_TICK_IN && mode_q != MODE_STOP)
            : (pre_tick && pre_q == 2'h3 && &div_q[5:0]);
        // Main clock: fast in normal and idle, slow in slow and sleep
        main_tick = slow_mode ? SLOW_TICK_IN : pre_tick; // see RL7 RL15 RL17
        tb_fall = tb_src_prev_q && !div_q[5'd8 + 5'(tb_sel)];
        // Oscillator plan follows the mode, so gates and mode move together
        single_mode = mode_q inside {MODE_NORMAL1, MODE_IDLE1, MODE_IDLE0}
            || (mode_q inside {MODE_STOP, MODE_WARMUP} && stop_from_q == MODE_NORMAL1);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || clear_div) begin
            pre_q <= '0; // see RL1 RL2
            div_q <= '0;
        end else begin
            if (pre_tick) begin
                pre_q <= pre_q + 2'h1;
            end
            if (pre_tick && pre_q == 2'h3) begin
                div_q[5:0] <= div_q[5:0] + 6'h01;
            end
            if (stage7_tick) begin
                div_q[DIVIDER_BITS-1:6] <= div_q[DIVIDER_BITS-1:6] + 15'h0001;
            end
        end
    end

    // Machine cycle state counter S0..S3
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state_q <= 2'h0;
            MACHINE_STATE_OUT <= 2'h0;
            CYCLE_START_OUT <= 1'b0;
            MAIN_CLK_EN_OUT <= 1'b0;
        end else begin
            MAIN_CLK_EN_OUT <= main_tick && GATES_OUT.cpu_clk_en;
            CYCLE_START_OUT <= main_tick && GATES_OUT.cpu_clk_en && state_q == 2'h3;
            if (main_tick && GATES_OUT.cpu_clk_en) begin
                state_q <= state_q + 2'h1; // see RL6
                MACHINE_STATE_OUT <= state_q + 2'h1; // see RL6
            end
        end
    end

    // Operating mode machine
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            mode_q <= MODE_NORMAL1; // see RL8 RL16
            stop_from_q <= MODE_NORMAL1;
            warm_q <= '0;
            tb_at_idle0_q <= 1'b0;
            IRQ_SERVICE_OUT <= 1'b0;
            RESUME_NEXT_OUT <= 1'b0;
            TB_IRQ_LATCH_OUT <= 1'b0;
        end else begin
            IRQ_SERVICE_OUT <= 1'b0;
            RESUME_NEXT_OUT <= 1'b0;
            TB_IRQ_LATCH_OUT <= 1'b0;
            case (mode_q)
                MODE_NORMAL1, MODE_NORMAL2, MODE_SLOW1, MODE_SLOW2: begin
                    if (ctrl_one_q[STOP_BIT]) begin
                        stop_from_q <= mode_q;
                        mode_q <= MODE_STOP;
                    end else if (ctrl_two_q[TIMING_GENERATOR_HALT_BIT]
                        && mode_q inside {MODE_NORMAL1, MODE_SLOW1}) begin
                        tb_at_idle0_q <= tb_ctrl_q[TB_EN_BIT];
                        mode_q <= slow_mode ? MODE_SLEEP0 : MODE_IDLE0; // see RL12 RL23
                    end else if (ctrl_two_q[IDLE_BIT]) begin
                        case (mode_q)
                            MODE_NORMAL1: mode_q <= MODE_IDLE1; // see RL9
                            MODE_NORMAL2: mode_q <= MODE_IDLE2; // see RL22
                            MODE_SLOW2: mode_q <= MODE_SLEEP2;
                            default: mode_q <= MODE_SLEEP1;
                        endcase
                    end else if (mode_q == MODE_NORMAL1 && ctrl_two_q[SLOW_EN_BIT]) begin
                        mode_q <= MODE_NORMAL2;
                    end else if (mode_q == MODE_NORMAL2 && !ctrl_two_q[SLOW_EN_BIT]) begin
                        mode_q <= MODE_NORMAL1;
                    end else if (mode_q == MODE_NORMAL2 && ctrl_two_q[SYSTEM_CLOCK_SELECT_BIT]) begin
                        mode_q <= MODE_SLOW2; // see RL18
                    end else if (mode_q == MODE_SLOW2 && !ctrl_two_q[SYSTEM_CLOCK_SELECT_BIT]) begin
                        mode_q <= MODE_NORMAL2; // see RL18 RL20
                    end else if (mode_q == MODE_SLOW2 && !ctrl_two_q[FAST_EN_BIT]) begin
                        mode_q <= MODE_SLOW1; // see RL19
                    end else if (mode_q == MODE_SLOW1 && ctrl_two_q[FAST_EN_BIT]) begin
                        mode_q <= MODE_SLOW2; // see RL19
                    end
                end
                MODE_IDLE1, MODE_IDLE2, MODE_SLEEP1, MODE_SLEEP2: begin
                    if (IRQ_REQ_IN) begin
                        IRQ_SERVICE_OUT <= IME_IN; // see RL10
                        RESUME_NEXT_OUT <= !IME_IN; // see RL11
                        case (mode_q)
                            MODE_IDLE1: mode_q <= MODE_NORMAL1; // see RL9
                            MODE_IDLE2: mode_q <= MODE_NORMAL2; // see RL22
                            MODE_SLEEP2: mode_q <= MODE_SLOW2;
                            default: mode_q <= MODE_SLOW1;
                        endcase
                    end
                end
                MODE_IDLE0, MODE_SLEEP0: begin
                    if (tb_fall) begin
                        mode_q <= mode_q == MODE_IDLE0 ? MODE_NORMAL1 : MODE_SLOW1; // see RL13 RL23
                        TB_IRQ_LATCH_OUT <= tb_at_idle0_q; // see RL14
                        IRQ_SERVICE_OUT <= tb_at_idle0_q && IME_IN && TB_IRQ_EN_IN; // see RL14
                    end
                end
                MODE_STOP: begin
                    if (STOP_RELEASE_IN) begin
                        warm_q <= warm_count(ctrl_one_q[WUT_LSB +: 2], ctrl_one_q[RETM_BIT]);
                        mode_q <= MODE_WARMUP;
                    end
                end
                MODE_WARMUP: begin
                    if ((ctrl_one_q[RETM_BIT] ? SLOW_TICK_IN : FAST_TICK_IN) && warm_q != '0) begin
                        warm_q <= warm_q - 17'h00001;
                    end else if (warm_q == '0) begin
                        RESUME_NEXT_OUT <= 1'b1; // see RL24
                        mode_q <= ctrl_one_q[RETM_BIT] ? MODE_SLOW1
                            : (stop_from_q == MODE_NORMAL2 ? MODE_NORMAL2 : MODE_NORMAL1);
                    end
                end
                default: mode_q <= MODE_NORMAL1;
            endcase
        end
    end

    // Control registers; stop, idle and halt requests self-clear on mode change
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            ctrl_one_q <= SYS_CTRL_ONE_RST;
            ctrl_two_q <= SYS_CTRL_TWO_RST;
            tb_ctrl_q <= TB_CTRL_RST;
        end else begin
            if (mode_q == MODE_STOP) begin
                ctrl_one_q[STOP_BIT] <= 1'b0;
            end
            if (!(mode_q inside {MODE_NORMAL1, MODE_NORMAL2, MODE_SLOW1, MODE_SLOW2})) begin
                ctrl_two_q[IDLE_BIT] <= 1'b0;
                ctrl_two_q[TIMING_GENERATOR_HALT_BIT] <= 1'b0;
            end
            if (wr_en && req.paddr_ok && req.paddr == SYS_CTRL_ONE_ADDR) begin
                ctrl_one_q <= req.pwdata[7:0];
            end
            if (wr_en && req.paddr_ok && req.paddr == SYS_CTRL_TWO_ADDR) begin
                ctrl_two_q <= req.pwdata[7:0];
            end
            if (wr_en && req.paddr_ok && req.paddr == TB_CTRL_ADDR) begin
                tb_ctrl_q <= req.pwdata[7:0];
            end
        end
    end

    always_comb begin
        case (req.paddr)
            SYS_CTRL_ONE_ADDR: rd_data = {24'h000000, ctrl_one_q};
            SYS_CTRL_TWO_ADDR: rd_data = {24'h000000, ctrl_two_q};
            TB_CTRL_ADDR: rd_data = {24'h000000, tb_ctrl_q};
            MODE_STAT_ADDR: rd_data = {26'h0, state_q, 4'(mode_q)};
            DIV_STAT_ADDR: rd_data = {11'h0, div_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // APB answer: no wait state, error on unmapped address
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h00000000;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN
                && (!req.paddr_ok || req.paddr > DIV_STAT_ADDR);
            PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !req.pwrite) ? rd_data : 32'h00000000;
        end
    end

    // Clock gates and divider taps
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            GATES_OUT <= '0;
            DIV_PULSE_OUT <= 1'b0;
            TB_SRC_OUT <= 8'h00;
            tb_src_prev_q <= 1'b0;
            MODE_OUT <= MODE_NORMAL1;
        end else begin
            MODE_OUT <= mode_q;
            tb_src_prev_q <= div_q[5'd8 + 5'(tb_sel)];
            DIV_PULSE_OUT <= div_q[12];
            TB_SRC_OUT <= div_q[DIVIDER_BITS-1 -: 8];
            GATES_OUT.cpu_clk_en <= mode_q inside {MODE_NORMAL1, MODE_NORMAL2, MODE_SLOW1,
                MODE_SLOW2};
            GATES_OUT.watchdog_run <= mode_q inside {MODE_NORMAL1, MODE_NORMAL2, MODE_SLOW1,
                MODE_SLOW2};
            GATES_OUT.periph_clk_en <= !(mode_q inside {MODE_IDLE0, MODE_SLEEP0, MODE_STOP,
                MODE_WARMUP}); // see RL12
            GATES_OUT.tb_clk_en <= !(mode_q inside {MODE_STOP, MODE_WARMUP});
            GATES_OUT.fast_osc_on <= !(mode_q inside {MODE_SLOW1, MODE_SLEEP1, MODE_SLEEP0,
                MODE_STOP}); // see RL19
            GATES_OUT.slow_osc_on <= !single_mode && mode_q != MODE_STOP; // see RL15
            GATES_OUT.slow_pins_port <= single_mode; // see RL7 RL15
        end
    end

endmodule : system_clock_mode_controller

// ---- verilog/clk_mode_pkg.sv ----
package clk_mode_pkg;

    // APB register map (byte addresses)
    localparam logic [7:0] SYS_CTRL_ONE_ADDR = 8'h00;
    localparam logic [7:0] SYS_CTRL_TWO_ADDR = 8'h04;
    localparam logic [7:0] TB_CTRL_ADDR = 8'h08;
    localparam logic [7:0] MODE_STAT_ADDR = 8'h0C;
    localparam logic [7:0] DIV_STAT_ADDR = 8'h10;

    // system_control_one fields
    localparam int STOP_BIT = 7;
    localparam int RETM_BIT = 5;
    localparam int WUT_LSB = 2;
    localparam logic [7:0] SYS_CTRL_ONE_RST = 8'h00;

    // system_control_two fields
    localparam int FAST_EN_BIT = 7;
    localparam int SLOW_EN_BIT = 6;
    localparam int SYSTEM_CLOCK_SELECT_BIT = 5;
    localparam int IDLE_BIT = 4;
    localparam int TIMING_GENERATOR_HALT_BIT = 2;
    localparam logic [7:0] SYS_CTRL_TWO_RST = 8'h80;

    // time_base_control fields
    localparam int DV7_BIT = 4;
    localparam int TB_EN_BIT = 3;
    localparam int TB_SEL_LSB = 0;
    localparam logic [7:0] TB_CTRL_RST = 8'h00;

    // Divider structure
    localparam int PRESCALE_BITS = 2;
    localparam int DIVIDER_BITS = 21;
    localparam int STATES_PER_CYCLE = 4;

    // Warm-up counts, in divider-input ticks (fast / slow)
    localparam logic [16:0] WARM_FAST_0 = 17'h30000;
    localparam logic [16:0] WARM_FAST_1 = 17'h10000;
    localparam logic [16:0] WARM_FAST_2 = 17'h0C000;
    localparam logic [16:0] WARM_FAST_3 = 17'h04000;
    localparam logic [16:0] WARM_SLOW_0 = 17'h06000;
    localparam logic [16:0] WARM_SLOW_1 = 17'h02000;
    localparam logic [16:0] WARM_SLOW_2 = 17'h000C0;
    localparam logic [16:0] WARM_SLOW_3 = 17'h00040;

    typedef enum logic [3:0] {
        MODE_NORMAL1, MODE_IDLE1, MODE_IDLE0, MODE_NORMAL2, MODE_IDLE2,
        MODE_SLOW2, MODE_SLEEP2, MODE_SLOW1, MODE_SLEEP1, MODE_SLEEP0,
        MODE_STOP, MODE_WARMUP
    } op_mode_e;

    typedef struct packed {
        logic paddr_ok;
        logic [7:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic tb_clk_en;
        logic watchdog_run;
        logic fast_osc_on;
        logic slow_osc_on;
        logic slow_pins_port;
    } clk_gate_s;

endpackage : clk_mode_pkg

// ---- dv/system_clock_mode_controller_chk.sv ----
module system_clock_mode_controller_chk (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // Observed ports
    input wire logic IRQ_REQ_IN,
    input wire logic IME_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire clk_mode_pkg::clk_gate_s GATES_OUT,
    input wire logic MAIN_CLK_EN_OUT,
    input wire logic [1:0] MACHINE_STATE_OUT,
    input wire logic CYCLE_START_OUT,
    input wire logic IRQ_SERVICE_OUT,
    input wire logic RESUME_NEXT_OUT,
    input wire clk_mode_pkg::op_mode_e MODE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    import clk_mode_pkg::*;
    logic [2:0] mc_q;
    logic full_q;
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    // Counts main clock ticks inside one machine cycle once the CPU runs steadily
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || !GATES_OUT.cpu_clk_en) begin
            mc_q <= 3'h0;
            full_q <= 1'h0;
        end else if (CYCLE_START_OUT) begin
            mc_q <= 3'h0;
            full_q <= 1'h1;
        end else if (MAIN_CLK_EN_OUT) begin
            mc_q <= mc_q + 3'h1;
        end
    end
    a_reset_normal: assert property ($fell(RST_IN) |-> MODE_OUT == MODE_NORMAL1)
        else $error("mode after reset is not NORMAL1");
    a_ready_next: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready in first access cycle");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside ready cycle");
    a_unmapped_err: assert property (PSEL_IN && !PENABLE_IN && PADDR_IN > 8'h10 |=> PSLVERR_OUT)
        else $error("unmapped access not refused");
    a_idle_service: assert property (MODE_OUT inside {MODE_IDLE1, MODE_IDLE2} &&
        $rose(IRQ_REQ_IN) && IME_IN |-> ##[0:3] IRQ_SERVICE_OUT)
        else $error("wake with master enable did not service");
    a_idle_resume: assert property (MODE_OUT inside {MODE_IDLE1, MODE_IDLE2} &&
        $rose(IRQ_REQ_IN) && !IME_IN |-> ##[0:3] RESUME_NEXT_OUT)
        else $error("wake without master enable did not resume");
    a_idle1_wake: assert property (MODE_OUT == MODE_IDLE1 && $rose(IRQ_REQ_IN)
        |-> ##[1:4] MODE_OUT == MODE_NORMAL1)
        else $error("IDLE1 not released to NORMAL1");
    a_idle2_wake: assert property (MODE_OUT == MODE_IDLE2 && $rose(IRQ_REQ_IN)
        |-> ##[1:4] MODE_OUT == MODE_NORMAL2)
        else $error("IDLE2 not released to NORMAL2");
    a_single_gates: assert property (MODE_OUT == MODE_NORMAL1 && !$past(RST_IN)
        |-> GATES_OUT.fast_osc_on && !GATES_OUT.slow_osc_on && GATES_OUT.slow_pins_port)
        else $error("single clock oscillator state wrong");
    a_idle_halt: assert property (MODE_OUT inside {MODE_IDLE0, MODE_IDLE1, MODE_IDLE2}
        |-> !GATES_OUT.cpu_clk_en && !GATES_OUT.watchdog_run)
        else $error("CPU or watchdog running in idle");
    a_idle0_tb: assert property (MODE_OUT inside {MODE_IDLE0, MODE_SLEEP0}
        |-> GATES_OUT.tb_clk_en && !GATES_OUT.periph_clk_en)
        else $error("halt mode peripheral gating wrong");
    a_dual_osc: assert property (MODE_OUT inside {MODE_NORMAL2, MODE_SLOW2}
        |-> GATES_OUT.slow_osc_on && GATES_OUT.fast_osc_on && !GATES_OUT.slow_pins_port)
        else $error("dual clock oscillator state wrong");
    a_slow1_fast: assert property (MODE_OUT == MODE_SLOW1 |-> !GATES_OUT.fast_osc_on)
        else $error("fast oscillator on in SLOW1");
    a_cycle_four: assert property (CYCLE_START_OUT && full_q
        |-> MAIN_CLK_EN_OUT && mc_q == 3'h3)
        else $error("machine cycle is not four main clocks");
    a_state_wrap: assert property (CYCLE_START_OUT |-> MACHINE_STATE_OUT == 2'h0)
        else $error("machine cycle did not wrap to S0");
endmodule : system_clock_mode_controller_chk

bind system_clock_mode_controller system_clock_mode_controller_chk chk_i (
    .SYS_CLK_IN, .RST_IN, .IRQ_REQ_IN, .IME_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN,
    .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .GATES_OUT, .MAIN_CLK_EN_OUT,
    .MACHINE_STATE_OUT, .CYCLE_START_OUT, .IRQ_SERVICE_OUT, .RESUME_NEXT_OUT, .MODE_OUT);

// ---- dv/test_system_clock_mode_controller.sv ----
module test_system_clock_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_mode_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic fast_tick = 1'h0, slow_tick = 1'h0, irq = 1'h0, ime = 1'h0, stop_rel = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, s;
    logic pready, pslverr, err, svc, res, tbl, divider_pulse_output;
    logic [7:0] tbs;
    logic [3:0] tick_q = 4'h0;
    clk_gate_s gates;
    op_mode_e mode;
    int n_errors = 0, n_tests = 0, n_svc = 0, n_res = 0, n_tbl = 0;

    system_clock_mode_controller uut (
        .SYS_CLK_IN(clk), .RST_IN(rst), .FAST_TICK_IN(fast_tick), .SLOW_TICK_IN(slow_tick),
        .IRQ_REQ_IN(irq), .IME_IN(ime), .TB_IRQ_EN_IN(1'h1), .STOP_RELEASE_IN(stop_rel),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .GATES_OUT(gates), .MAIN_CLK_EN_OUT(), .MACHINE_STATE_OUT(), .CYCLE_START_OUT(),
        .DIV_PULSE_OUT(divider_pulse_output), .TB_SRC_OUT(tbs), .IRQ_SERVICE_OUT(svc), .RESUME_NEXT_OUT(res),
        .TB_IRQ_LATCH_OUT(tbl), .MODE_OUT(mode));

    initial begin
        forever #25 clk = ~clk;
    end

    // Oscillator ticks exist only while the oscillator is switched on
    always @(posedge clk) begin
        tick_q <= tick_q + 4'h1;
        fast_tick <= tick_q[0] & gates.fast_osc_on;
        slow_tick <= (tick_q == 4'hF) & gates.slow_osc_on;
        if (svc === 1'h1) n_svc++;
        if (res === 1'h1) n_res++;
        if (tbl === 1'h1) n_tbl++;
    end

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 16);
        chk("pready", 32'h1, 32'(pready));
        if (pready !== 1'h1) print_verdict();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task wait_mode(input op_mode_e m, input int lim);
        int i;
        i = 0;
        while (mode !== m && i < lim) begin
            @(posedge clk);
            i++;
        end
        chk("mode", 32'(m), 32'(mode));
        if (mode !== m) print_verdict();
    endtask : wait_mode

    task wr2(input logic [31:0] d, input op_mode_e m, input int lim);
        apb(1'h1, SYS_CTRL_TWO_ADDR, d);
        wait_mode(m, lim);
    endtask : wr2

    task t_reset;
        chk("mode", 32'(MODE_NORMAL1), 32'(mode));
        chk("gates", 32'h7D, 32'(gates));
        chk("divider taps", 32'h0, {23'h0, tbs, divider_pulse_output});
        apb(1'h0, SYS_CTRL_ONE_ADDR, 32'h0);
        chk("ctrl_one", 32'(SYS_CTRL_ONE_RST), rd);
        apb(1'h0, SYS_CTRL_TWO_ADDR, 32'h0);
        chk("ctrl_two", 32'(SYS_CTRL_TWO_RST), rd);
        apb(1'h0, TB_CTRL_ADDR, 32'h0);
        chk("tb_ctrl", 32'(TB_CTRL_RST), rd);
        apb(1'h0, MODE_STAT_ADDR, 32'h0);
        chk("status mode", 32'(MODE_NORMAL1), {28'h0, rd[3:0]});
        $display("test reset done");
    endtask : t_reset

    task t_apb_err;
        apb(1'h0, 8'h14, 32'h0);
        chk("err high", 32'h1, 32'(err));
        chk("rdata high", 32'h0, rd);
        apb(1'h1, 8'h01, 32'hFF);
        chk("err unaligned", 32'h1, 32'(err));
        apb(1'h0, SYS_CTRL_ONE_ADDR, 32'h0);
        chk("ctrl_one kept", 32'h0, rd);
        chk("err ok", 32'h0, 32'(err));
        $display("test apb errors done");
    endtask : t_apb_err

    task t_idle;
        for (int k = 1; k >= 0; k--) begin
            ime <= k[0];
            n_svc = 0;
            n_res = 0;
            wr2(32'h90, MODE_IDLE1, 8);
            chk("idle1 gates", 32'h35, 32'(gates));
            irq <= 1'h1;
            wait_mode(MODE_NORMAL1, 8);
            irq <= 1'h0;
            repeat (2) @(posedge clk);
            chk("service pulses", 32'(k), 32'(n_svc));
            chk("resume pulses", 32'(1 - k), 32'(n_res));
        end
        apb(1'h0, SYS_CTRL_TWO_ADDR, 32'h0);
        chk("idle bit cleared", 32'h80, rd);
        $display("test idle1 done");
    endtask : t_idle

    task t_idle0;
        for (int en = 1; en >= 0; en--) begin
            n_tbl = 0;
            apb(1'h1, TB_CTRL_ADDR, 32'(en) << TB_EN_BIT);
            wr2(32'h84, MODE_IDLE0, 8);
            chk("idle0 gates", 32'h15, 32'(gates));
            wait_mode(MODE_NORMAL1, 12000);
            repeat (2) @(posedge clk);
            chk("tb latch pulses", 32'(en), 32'(n_tbl));
        end
        $display("test idle0 done");
    endtask : t_idle0

    task t_dual;
        wr2(32'hC0, MODE_NORMAL2, 8);
        chk("normal2 gates", 32'h7E, 32'(gates));
        wr2(32'hE0, MODE_SLOW2, 8);
        wr2(32'h60, MODE_SLOW1, 8);
        apb(1'h0, DIV_STAT_ADDR, 32'h0);
        s = rd;
        repeat (40) @(posedge clk);
        apb(1'h0, DIV_STAT_ADDR, 32'h0);
        chk("low stages", {26'h0, s[5:0]}, {26'h0, rd[5:0]});
        wr2(32'h64, MODE_SLEEP0, 8);
        wait_mode(MODE_SLOW1, 20000);
        n_res = 0;
        apb(1'h1, SYS_CTRL_ONE_ADDR, 32'hAC);
        wait_mode(MODE_STOP, 8);
        stop_rel <= 1'h1;
        @(posedge clk);
        stop_rel <= 1'h0;
        wait_mode(MODE_SLOW1, 1500);
        repeat (2) @(posedge clk);
        chk("stop resume pulses", 32'h1, 32'(n_res));
        wr2(32'hE0, MODE_SLOW2, 8);
        wr2(32'hC0, MODE_NORMAL2, 8);
        wr2(32'hD0, MODE_IDLE2, 8);
        irq <= 1'h1;
        wait_mode(MODE_NORMAL2, 8);
        irq <= 1'h0;
        wr2(32'h80, MODE_NORMAL1, 8);
        $display("test dual clock done");
    endtask : t_dual

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (3) @(posedge clk);
        t_reset();
        t_apb_err();
        t_idle();
        t_idle0();
        t_dual();
        print_verdict();
    end
endmodule : test_system_clock_mode_controller
